// ---- hw/gauge_pkg.sv ----
package gauge_pkg;
	// ----------------------------------------
	// Register word indices
	// ----------------------------------------
	localparam logic [4:0] CONFIG_IDX = 5'h00;
	localparam logic [4:0] CAP_LOW_SET_IDX = 5'h01;
	localparam logic [4:0] CAP_LOW_CLR_IDX = 5'h02;
	localparam logic [4:0] SHUT_SET_IDX = 5'h03;
	localparam logic [4:0] SHUT_CLR_IDX = 5'h04;
	localparam logic [4:0] FINAL_V_IDX = 5'h05;
	localparam logic [4:0] DESIGN_CAP_IDX = 5'h06;
	localparam logic [4:0] DESIGN_ENERGY_IDX = 5'h07;
	localparam logic [4:0] AT_RATE_IDX = 5'h08;
	localparam logic [4:0] USER_RATE_IDX = 5'h09;
	localparam logic [4:0] RESERVE_MAH_IDX = 5'h0a;
	localparam logic [4:0] RESERVE_MWH_IDX = 5'h0b;
	localparam logic [4:0] FULL_CAP_IDX = 5'h0c;
	localparam logic [4:0] STATUS_IDX = 5'h0d;
	localparam logic [4:0] REMAIN_IDX = 5'h0e;
	localparam logic [4:0] SOC_IDX = 5'h0f;
	localparam logic [4:0] LOAD_RATE_IDX = 5'h10;
	localparam logic [4:0] NOM_AVAIL_IDX = 5'h11;
	localparam logic [4:0] FCC_IDX = 5'h12;
	localparam logic [4:0] CHARGE_IDX = 5'h13;
	localparam logic [4:0] ENERGY_IDX = 5'h14;
	// ----------------------------------------
	// Configuration word fields
	// ----------------------------------------
	localparam int LOW_EN_BIT = 0;
	localparam int LOW_POL_BIT = 1;
	localparam int LOAD_MODE_BIT = 2;
	localparam int LOAD_SEL_LSB = 4;
	// Status word fields.
	localparam int CAP_FLAG_BIT = 0;
	localparam int SHUT_FLAG_BIT = 1;
	localparam int LOAD_STAT_BIT = 2;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic LOW_POL_RST = 1'b1;
	localparam logic [2:0] LOAD_SEL_RST = 3'h1;
	localparam logic [15:0] FULL_CAP_RST = 16'h03e8;
	// ----------------------------------------
	// Timing and scaling
	// ----------------------------------------
	localparam int UPDATE_PERIOD_S = 1;
	localparam int SEC_PER_HOUR = 3600;
	localparam int FILT_TAU_S = 14;
	localparam int FILT_DIV = FILT_TAU_S / UPDATE_PERIOD_S;
	localparam int C_RATE_DIV = 5;
	localparam int POWER_UNIT_MW = 10;
	localparam int LOSS_DIV = 8;
	localparam int AVG_SHIFT = 2;
	// Load model selected by the configuration word.
	typedef enum logic {LOAD_CURRENT = 1'b0, LOAD_POWER = 1'b1} load_mode_e;
endpackage : gauge_pkg

// ---- hw/charge_warning_load_model.sv ----
`timescale 1ns/10ps
// Contract
// - Integrate sense current into charge state.
// - Set capacity-low flag below set threshold.
// - Clear capacity-low flag above clear threshold.
// - Low-charge pin follows capacity-low flag.
// - Drive low indication only when enabled.
// - Low voltage sets shutdown flag, pulses event.
// - Voltage above clear clears flag, pulses event.
// - Final voltage forces state of charge zero.
// - Load mode 0 current, 1 power.
// - Mirror load mode into status bit.
// - Current mode selects one of seven sources.
// - Power mode selects power versions of sources.
// - Source 3 uses 14 s filtered current.
// - Source 4 uses design value over five.
// - Keep mAh reserve beyond zero remaining.
// - Keep mWh reserve, uncompensated reserves.
// - Report full charge capacity under load.
// - Report uncompensated nominal and full capacity.
// - Polarity bit set means active-high pin.
module charge_warning_load_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [15:0] sense_pos_input,
	input wire logic [15:0] sense_neg_input,
	input wire logic [15:0] voltage_mv,
	input wire logic meas_valid,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic low_charge_pin,
	output logic charge_event_pin,
	output logic capacity_low_flag,
	output logic shutdown_warn_flag
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Clamp a wide signed value into the unsigned 16-bit range.
	function automatic logic [15:0] sat16(input longint x);
		if (x < 0) return 16'h0000;
		if (x > 65535) return 16'hffff;
		return x[15:0];
	endfunction : sat16

	// Current in mA times voltage in mV, as mW.
	function automatic logic signed [15:0] pwr(input logic signed [15:0] i, input logic [15:0] v);
		longint p;
		p = (longint'(i) * longint'(v)) / 1000;
		return p[15:0];
	endfunction : pwr

	// Running sum over a sample count, guarded against an empty count.
	function automatic logic signed [15:0] mean(input logic signed [31:0] s, input logic [15:0] n);
		longint q;
		q = (n == 16'h0000) ? 0 : longint'(s) / longint'(n);
		return q[15:0];
	endfunction : mean

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	logic low_pin_enable;
	logic low_pin_polarity;
	gauge_pkg::load_mode_e load_mode;
	logic [2:0] load_sel;
	logic [15:0] cap_low_set, cap_low_clr, shut_set, shut_clr, final_v;
	logic [15:0] design_cap, design_energy, reserve_mah, reserve_mwh, full_cap;
	logic signed [15:0] at_rate, user_rate;
	wire wr_charge = reg_wr && reg_addr == gauge_pkg::CHARGE_IDX;

	// Register writes; the charge word lets software seed the counter.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			low_pin_enable <= 1'b0;
			low_pin_polarity <= gauge_pkg::LOW_POL_RST;
			load_mode <= gauge_pkg::LOAD_CURRENT;
			load_sel <= gauge_pkg::LOAD_SEL_RST;
			cap_low_set <= 16'h0000;
			cap_low_clr <= 16'h0000;
			shut_set <= 16'h0000;
			shut_clr <= 16'h0000;
			final_v <= 16'h0000;
			design_cap <= 16'h0000;
			design_energy <= 16'h0000;
			at_rate <= 16'sh0000;
			user_rate <= 16'sh0000;
			reserve_mah <= 16'h0000;
			reserve_mwh <= 16'h0000;
			full_cap <= gauge_pkg::FULL_CAP_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				gauge_pkg::CONFIG_IDX: begin
					low_pin_enable <= reg_wdata[gauge_pkg::LOW_EN_BIT];
					low_pin_polarity <= reg_wdata[gauge_pkg::LOW_POL_BIT];
					load_mode <= gauge_pkg::load_mode_e'(reg_wdata[gauge_pkg::LOAD_MODE_BIT]);
					load_sel <= reg_wdata[gauge_pkg::LOAD_SEL_LSB +: 3];
				end
				gauge_pkg::CAP_LOW_SET_IDX: cap_low_set <= reg_wdata;
				gauge_pkg::CAP_LOW_CLR_IDX: cap_low_clr <= reg_wdata;
				gauge_pkg::SHUT_SET_IDX: shut_set <= reg_wdata;
				gauge_pkg::SHUT_CLR_IDX: shut_clr <= reg_wdata;
				gauge_pkg::FINAL_V_IDX: final_v <= reg_wdata;
				gauge_pkg::DESIGN_CAP_IDX: design_cap <= reg_wdata;
				gauge_pkg::DESIGN_ENERGY_IDX: design_energy <= reg_wdata;
				gauge_pkg::AT_RATE_IDX: at_rate <= reg_wdata;
				gauge_pkg::USER_RATE_IDX: user_rate <= reg_wdata;
				gauge_pkg::RESERVE_MAH_IDX: reserve_mah <= reg_wdata;
				gauge_pkg::RESERVE_MWH_IDX: reserve_mwh <= reg_wdata;
				gauge_pkg::FULL_CAP_IDX: full_cap <= reg_wdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Charge integration
	// ----------------------------------------
	// Positive current is charge, negative is discharge.
	wire logic signed [15:0] cur = signed'(sense_pos_input - sense_neg_input);
	logic signed [31:0] coul;
	logic [15:0] charge_mah;
	logic signed [31:0] next_coul;
	logic [15:0] next_mah;
	localparam int MAS_PER_MAH = gauge_pkg::SEC_PER_HOUR;
	wire logic signed [31:0] coul_sum = coul + 32'(cur) * 32'(gauge_pkg::UPDATE_PERIOD_S);

	// Whole mAh leave the mA-second remainder; the count is held between zero and full.
	always_comb begin
		next_coul = coul_sum;
		next_mah = charge_mah;
		if (coul_sum >= MAS_PER_MAH) begin
			next_coul = coul_sum - MAS_PER_MAH;
			if (charge_mah < full_cap) next_mah = charge_mah + 16'h0001;
		end else if (coul_sum <= -MAS_PER_MAH) begin
			next_coul = coul_sum + MAS_PER_MAH;
			if (charge_mah != 16'h0000) next_mah = charge_mah - 16'h0001;
		end
	end

	// ----------------------------------------
	// Current averages for the load sources
	// ----------------------------------------
	logic signed [15:0] avg_i, filt_i, prev_i, prev_p;
	logic signed [31:0] dsg_i_sum, dsg_p_sum;
	logic [15:0] dsg_cnt;
	logic in_dsg;
	wire logic dsg_now = cur < 0;
	wire logic signed [15:0] pres_i = in_dsg ? mean(dsg_i_sum, dsg_cnt) : prev_i;
	wire logic signed [15:0] pres_p = in_dsg ? mean(dsg_p_sum, dsg_cnt) : prev_p;
	wire logic signed [15:0] avg_step = (cur - avg_i) >>> gauge_pkg::AVG_SHIFT;
	wire logic signed [15:0] filt_step = 16'((32'(avg_i) - 32'(filt_i)) / gauge_pkg::FILT_DIV);

	// One update per measurement; the filter step gives a 14 s time constant.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			coul <= 32'sh0;
			charge_mah <= 16'h0000;
			avg_i <= 16'sh0000;
			filt_i <= 16'sh0000;
			prev_i <= 16'sh0000;
			prev_p <= 16'sh0000;
			dsg_i_sum <= 32'sh0;
			dsg_p_sum <= 32'sh0;
			dsg_cnt <= 16'h0000;
			in_dsg <= 1'b0;
		end else if (wr_charge) begin
			coul <= 32'sh0;
			charge_mah <= reg_wdata;
		end else if (meas_valid) begin
			coul <= next_coul;
			charge_mah <= next_mah;
			avg_i <= avg_i + avg_step;
			filt_i <= filt_i + filt_step;
			in_dsg <= dsg_now;
			if (dsg_now) begin
				dsg_i_sum <= in_dsg ? dsg_i_sum + 32'(cur) : 32'(cur);
				dsg_p_sum <= in_dsg ? dsg_p_sum + 32'(pwr(cur, voltage_mv)) : 32'(pwr(cur, voltage_mv));
				dsg_cnt <= in_dsg ? dsg_cnt + 16'h0001 : 16'h0001;
			end else if (in_dsg) begin
				prev_i <= pres_i; // End of a discharge cycle keeps its average.
				prev_p <= pres_p;
			end
		end
	end

	// ----------------------------------------
	// Load rate selection
	// ----------------------------------------
	logic signed [15:0] rate;
	wire logic signed [15:0] c5_rate = 16'(design_cap / 16'(gauge_pkg::C_RATE_DIV));
	wire logic signed [15:0] e5_rate = 16'(design_energy / 16'(gauge_pkg::C_RATE_DIV));

	// Code 7 has no meaning and falls back to the present-cycle average.
	always_comb begin
		if (load_mode == gauge_pkg::LOAD_CURRENT) begin
			unique case (load_sel)
				3'h0: rate = prev_i;
				3'h2: rate = avg_i;
				3'h3: rate = filt_i;
				3'h4: rate = c5_rate;
				3'h5: rate = at_rate;
				3'h6: rate = user_rate;
				default: rate = pres_i;
			endcase
		end else begin
			unique case (load_sel)
				3'h0: rate = prev_p;
				3'h2: rate = pwr(avg_i, voltage_mv);
				3'h3: rate = pwr(filt_i, voltage_mv);
				3'h4: rate = e5_rate;
				3'h5: rate = 16'(32'(at_rate) * gauge_pkg::POWER_UNIT_MW);
				3'h6: rate = 16'(32'(user_rate) * gauge_pkg::POWER_UNIT_MW);
				default: rate = pres_p;
			endcase
		end
	end

	// ----------------------------------------
	// Compensated capacities
	// ----------------------------------------
	// The loss term is a simple rate penalty; the reserves are never penalised,
	// which is the no-load compensation they call for.
	wire logic [15:0] rate_mag = rate[15] ? 16'(-rate) : 16'(rate);
	wire logic [15:0] loss = rate_mag / 16'(gauge_pkg::LOSS_DIV);
	wire logic [15:0] fcc_w = sat16(longint'(full_cap) - longint'(loss));
	wire logic [15:0] rem_w = sat16(longint'(next_mah) - longint'(loss) - longint'(reserve_mah));
	wire logic [15:0] energy_w = sat16(longint'(rem_w) * longint'(voltage_mv) / 1000 - longint'(reserve_mwh));
	wire logic final_hit = voltage_mv <= final_v;
	wire logic [15:0] soc_w = (final_hit || fcc_w == 16'h0000) ? 16'h0000 : sat16(longint'(rem_w) * 100 / longint'(fcc_w));
	logic [15:0] remain, soc, load_rate, energy, fcc;

	// Reported values move only with a measurement.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			remain <= 16'h0000;
			soc <= 16'h0000;
			load_rate <= 16'h0000;
			energy <= 16'h0000;
			fcc <= 16'h0000;
		end else if (meas_valid) begin
			remain <= rem_w;
			soc <= (soc_w > 16'h0064) ? 16'h0064 : soc_w;
			load_rate <= rate;
			energy <= energy_w;
			fcc <= fcc_w;
		end
	end

	// ----------------------------------------
	// Warning flags and pins
	// ----------------------------------------
	// Separate set and clear thresholds give hysteresis so the flags cannot chatter.
	wire logic next_cap_flag = !meas_valid ? capacity_low_flag :
		(rem_w < cap_low_set) ? 1'b1 :
		(rem_w > cap_low_clr) ? 1'b0 : capacity_low_flag;
	wire logic next_shut_flag = !meas_valid ? shutdown_warn_flag :
		(voltage_mv < shut_set) ? 1'b1 :
		(shutdown_warn_flag && voltage_mv > shut_clr) ? 1'b0 : shutdown_warn_flag;
	wire logic low_active = low_pin_enable && next_cap_flag;

	// Flags, the pin level and the event pulse change on the same edge.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			capacity_low_flag <= 1'b0;
			shutdown_warn_flag <= 1'b0;
			low_charge_pin <= 1'b0;
			charge_event_pin <= 1'b0;
		end else begin
			capacity_low_flag <= next_cap_flag;
			shutdown_warn_flag <= next_shut_flag;
			low_charge_pin <= low_active ? low_pin_polarity : !low_pin_polarity;
			charge_event_pin <= next_shut_flag != shutdown_warn_flag;
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	wire logic [15:0] config_word = {9'h000, load_sel, 1'b0, load_mode, low_pin_polarity, low_pin_enable};
	wire logic [15:0] status_word = {13'h0000, load_mode, shutdown_warn_flag, capacity_low_flag};
	logic [15:0] read_mux;

	// Unmapped words read as zero.
	always_comb begin
		unique case (reg_addr)
			gauge_pkg::CONFIG_IDX: read_mux = config_word;
			gauge_pkg::CAP_LOW_SET_IDX: read_mux = cap_low_set;
			gauge_pkg::CAP_LOW_CLR_IDX: read_mux = cap_low_clr;
			gauge_pkg::SHUT_SET_IDX: read_mux = shut_set;
			gauge_pkg::SHUT_CLR_IDX: read_mux = shut_clr;
			gauge_pkg::FINAL_V_IDX: read_mux = final_v;
			gauge_pkg::DESIGN_CAP_IDX: read_mux = design_cap;
			gauge_pkg::DESIGN_ENERGY_IDX: read_mux = design_energy;
			gauge_pkg::AT_RATE_IDX: read_mux = at_rate;
			gauge_pkg::USER_RATE_IDX: read_mux = user_rate;
			gauge_pkg::RESERVE_MAH_IDX: read_mux = reserve_mah;
			gauge_pkg::RESERVE_MWH_IDX: read_mux = reserve_mwh;
			gauge_pkg::FULL_CAP_IDX: read_mux = full_cap;
			gauge_pkg::STATUS_IDX: read_mux = status_word;
			gauge_pkg::REMAIN_IDX: read_mux = remain;
			gauge_pkg::SOC_IDX: read_mux = soc;
			gauge_pkg::LOAD_RATE_IDX: read_mux = load_rate;
			gauge_pkg::NOM_AVAIL_IDX: read_mux = charge_mah;
			gauge_pkg::FCC_IDX: read_mux = fcc;
			gauge_pkg::CHARGE_IDX: read_mux = charge_mah;
			gauge_pkg::ENERGY_IDX: read_mux = energy;
			default: read_mux = 16'h0000;
		endcase
	end

	// Read data stand for exactly one cycle after the strobe.
	always_ff @(posedge mclk) begin
		if (!rst_n) reg_rdata <= 16'h0000;
		else reg_rdata <= reg_rd ? read_mux : 16'h0000;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Named steps of an update, shared by the capacity-low and load-source checks.
	sequence upd_low_s;
		meas_valid && rem_w < cap_low_set;
	endsequence
	sequence upd_high_s;
		meas_valid && rem_w > cap_low_clr && rem_w >= cap_low_set;
	endsequence
	sequence upd_filt_s;
		meas_valid && load_mode == gauge_pkg::LOAD_CURRENT && load_sel == 3'h3;
	endsequence

	// Flag checks look one edge after the update that moved them.
	cap_set_a: assert property (@(posedge mclk) disable iff (!rst_n) upd_low_s |=> capacity_low_flag)
		else $error("capacity-low flag not set");
	cap_clear_a: assert property (@(posedge mclk) disable iff (!rst_n) upd_high_s |=> !capacity_low_flag)
		else $error("capacity-low flag not cleared");
	cap_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) !meas_valid |=> $stable(capacity_low_flag))
		else $error("capacity-low flag moved without update");
	// The pin register is one edge behind the configuration, so the settings of the edge before are used.
	pin_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
		##1 low_charge_pin == (($past(low_pin_enable) && capacity_low_flag) ?
		$past(low_pin_polarity) : !$past(low_pin_polarity)))
		else $error("low-charge pin does not follow flag");
	pin_disabled_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!low_pin_enable ##1 ($stable(low_pin_enable) && $stable(low_pin_polarity))
		|-> low_charge_pin == !low_pin_polarity)
		else $error("low-charge pin active while disabled");
	shut_event_a: assert property (@(posedge mclk) disable iff (!rst_n)
		meas_valid && voltage_mv < shut_set && !shutdown_warn_flag |=> shutdown_warn_flag && charge_event_pin ##1 !charge_event_pin)
		else $error("shutdown set without event pulse");
	shut_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		meas_valid && shutdown_warn_flag && voltage_mv > shut_clr && voltage_mv >= shut_set |=> !shutdown_warn_flag && charge_event_pin)
		else $error("shutdown clear without event pulse");
	soc_zero_a: assert property (@(posedge mclk) disable iff (!rst_n) meas_valid && final_hit |=> soc == 16'h0000)
		else $error("state of charge not zero at final voltage");
	mode_mirror_a: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_rd && reg_addr == gauge_pkg::STATUS_IDX |=> reg_rdata[gauge_pkg::LOAD_STAT_BIT] == $past(load_mode))
		else $error("load status bit differs from mode");
	// Read data must fall back to zero, or a host could take a stale word for a fresh one.
	rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_n) !reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data stand outside the read cycle");
	filt_src_a: assert property (@(posedge mclk) disable iff (!rst_n) upd_filt_s |=> load_rate == $past(filt_i))
		else $error("filtered source not taken as load rate");
	event_change_a: assert property (@(posedge mclk) disable iff (!rst_n)
		charge_event_pin |-> shutdown_warn_flag != $past(shutdown_warn_flag))
		else $error("event pulse without a shutdown flag change");
endmodule : charge_warning_load_model

// ---- tb/battery_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Cell and sense resistor seen from the gauge
// ----------------------------------------
module battery_model (
	input wire logic mclk,
	output logic [15:0] sense_pos_input,
	output logic [15:0] sense_neg_input,
	output logic [15:0] voltage_mv,
	output logic meas_valid
);
	// The negative node sits at a fixed code, so the difference carries the signed current.
	localparam logic [15:0] SENSE_BASE = 16'h1000;

	// Idle cell: no current, a healthy voltage, no update pending.
	initial begin
		sense_pos_input = SENSE_BASE;
		sense_neg_input = SENSE_BASE;
		voltage_mv = 16'h0e74;
		meas_valid = 1'b0;
	end

	// Current and voltage stay as levels, because a real cell keeps flowing between updates.
	task automatic measure(input logic [15:0] cur_ma, input logic [15:0] mv);
		@(posedge mclk);
		sense_pos_input <= SENSE_BASE + cur_ma;
		voltage_mv <= mv;
		meas_valid <= 1'b1;
		@(posedge mclk);
		meas_valid <= 1'b0;
	endtask : measure
endmodule : battery_model

// ---- tb/charge_warning_load_model_bench.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Bench for the charge warning and load model block
// ----------------------------------------
module charge_warning_load_model_bench;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] sense_pos_input, sense_neg_input, voltage_mv, reg_wdata, reg_rdata;
	logic meas_valid, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic low_charge_pin, charge_event_pin, capacity_low_flag, shutdown_warn_flag;
	int miscompares = 0;
	int cmp_count = 0;
	logic [15:0] load_tab [6][4];

	initial reg_wdata = 16'h0000;

	// Free-running 100 MHz clock.
	always #5 mclk = ~mclk;

	charge_warning_load_model charge_warning_load_model_inst (.mclk(mclk), .rst_n(rst_n),
		.sense_pos_input(sense_pos_input), .sense_neg_input(sense_neg_input), .voltage_mv(voltage_mv),
		.meas_valid(meas_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_charge_pin(low_charge_pin),
		.charge_event_pin(charge_event_pin), .capacity_low_flag(capacity_low_flag),
		.shutdown_warn_flag(shutdown_warn_flag));

	battery_model battery_model_inst (.mclk(mclk), .sense_pos_input(sense_pos_input),
		.sense_neg_input(sense_neg_input), .voltage_mv(voltage_mv), .meas_valid(meas_valid));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [4:0] addr, input logic [15:0] data);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= addr;
		reg_wdata <= data;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so they are sampled mid-cycle there.
	task automatic rd(input logic [4:0] addr, input logic [15:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= addr;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		check(reg_rdata, exp);
	endtask : rd

	// One update, then the capacity-low flag and the low-charge pin seen once the update edge has landed.
	task automatic upd(input logic [15:0] cur, input logic [15:0] mv, input logic cap, input logic pin);
		battery_model_inst.measure(cur, mv);
		@(negedge mclk);
		check({15'h0, capacity_low_flag}, {15'h0, cap});
		check({15'h0, low_charge_pin}, {15'h0, pin});
	endtask : upd

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	// A hang is cut short here; the bench never waits on the design otherwise.
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		wrap_up();
	end

	// Load table rows: configuration word, expected load rate, expected full charge capacity, expected status word.
	initial begin
		load_tab = '{'{16'h0043, 16'h00c8, 16'h03cf, 16'h0}, '{16'h0053, 16'hff38, 16'h03cf, 16'h0},
			'{16'h0063, 16'hff9c, 16'h03dc, 16'h0}, '{16'h0047, 16'h03e8, 16'h036b, 16'h4},
			'{16'h0057, 16'hf830, 16'h02ee, 16'h4}, '{16'h0067, 16'hfc18, 16'h036b, 16'h4}};
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		check({15'h0, low_charge_pin}, 16'h0000);
		rd(gauge_pkg::CONFIG_IDX, 16'h0012);
		rd(gauge_pkg::FULL_CAP_IDX, 16'h03e8);
		wr(gauge_pkg::STATUS_IDX, 16'hffff);
		rd(gauge_pkg::STATUS_IDX, 16'h0000);
		rd(5'h1f, 16'h0000);
		$display("test reset_and_map done");

		// Charge integration: 3600 mA for one second is exactly one mAh either way.
		wr(gauge_pkg::CONFIG_IDX, 16'h0063);
		wr(gauge_pkg::CHARGE_IDX, 16'h0064);
		upd(16'h0e10, 16'h0e74, 1'b0, 1'b0);
		rd(gauge_pkg::CHARGE_IDX, 16'h0065);
		upd(16'hf1f0, 16'h0e74, 1'b0, 1'b0);
		rd(gauge_pkg::CHARGE_IDX, 16'h0064);
		rd(gauge_pkg::NOM_AVAIL_IDX, 16'h0064);
		wr(gauge_pkg::RESERVE_MAH_IDX, 16'h000a);
		upd(16'h0000, 16'h0e74, 1'b0, 1'b0);
		rd(gauge_pkg::REMAIN_IDX, 16'h005a);
		rd(gauge_pkg::ENERGY_IDX, 16'h014d);
		wr(gauge_pkg::RESERVE_MAH_IDX, 16'h0000);
		$display("test charge_count done");

		// Capacity-low hysteresis between 50 and 60 mAh, then polarity and enable of the pin.
		wr(gauge_pkg::CAP_LOW_SET_IDX, 16'h0032);
		wr(gauge_pkg::CAP_LOW_CLR_IDX, 16'h003c);
		wr(gauge_pkg::CHARGE_IDX, 16'h0037);
		upd(16'h0000, 16'h0e74, 1'b0, 1'b0);
		wr(gauge_pkg::CHARGE_IDX, 16'h002d);
		upd(16'h0000, 16'h0e74, 1'b1, 1'b1);
		rd(gauge_pkg::STATUS_IDX, 16'h0001);
		wr(gauge_pkg::CHARGE_IDX, 16'h0037);
		upd(16'h0000, 16'h0e74, 1'b1, 1'b1);
		wr(gauge_pkg::CHARGE_IDX, 16'h003d);
		upd(16'h0000, 16'h0e74, 1'b0, 1'b0);
		wr(gauge_pkg::CONFIG_IDX, 16'h0061);
		wr(gauge_pkg::CHARGE_IDX, 16'h002d);
		upd(16'h0000, 16'h0e74, 1'b1, 1'b0);
		wr(gauge_pkg::CONFIG_IDX, 16'h0060);
		battery_model_inst.measure(16'h0000, 16'h0e74);
		@(negedge mclk);
		check({15'h0, low_charge_pin}, 16'h0001);
		$display("test capacity_low done");

		// State of charge is half, then forced to zero at the final voltage.
		wr(gauge_pkg::CONFIG_IDX, 16'h0063);
		wr(gauge_pkg::CHARGE_IDX, 16'h01f4);
		wr(gauge_pkg::FINAL_V_IDX, 16'h0bb8);
		upd(16'h0000, 16'h0e74, 1'b0, 1'b0);
		rd(gauge_pkg::SOC_IDX, 16'h0032);
		upd(16'h0000, 16'h0bae, 1'b0, 1'b0);
		rd(gauge_pkg::SOC_IDX, 16'h0000);
		$display("test final_voltage done");

		// Shutdown warning set below 3000 mV, held at 3100 mV, cleared above 3300 mV.
		wr(gauge_pkg::SHUT_SET_IDX, 16'h0bb8);
		wr(gauge_pkg::SHUT_CLR_IDX, 16'h0ce4);
		battery_model_inst.measure(16'h0000, 16'h0b54);
		@(negedge mclk);
		check({15'h0, shutdown_warn_flag}, 16'h0001);
		check({15'h0, charge_event_pin}, 16'h0001);
		@(negedge mclk);
		check({15'h0, charge_event_pin}, 16'h0000);
		rd(gauge_pkg::STATUS_IDX, 16'h0002);
		battery_model_inst.measure(16'h0000, 16'h0c1c);
		@(negedge mclk);
		check({14'h0, shutdown_warn_flag, charge_event_pin}, 16'h0002);
		battery_model_inst.measure(16'h0000, 16'h0d48);
		@(negedge mclk);
		check({14'h0, shutdown_warn_flag, charge_event_pin}, 16'h0001);
		$display("test shutdown_warning done");

		// Load sources 4, 5 and 6 in both models, with their effect on full charge capacity.
		wr(gauge_pkg::DESIGN_CAP_IDX, 16'h03e8);
		wr(gauge_pkg::DESIGN_ENERGY_IDX, 16'h1388);
		wr(gauge_pkg::AT_RATE_IDX, 16'hff38);
		wr(gauge_pkg::USER_RATE_IDX, 16'hff9c);
		for (int i = 0; i < 6; i++) begin
			wr(gauge_pkg::CONFIG_IDX, load_tab[i][0]);
			upd(16'h0000, 16'h0e74, 1'b0, 1'b0);
			rd(gauge_pkg::LOAD_RATE_IDX, load_tab[i][1]);
			rd(gauge_pkg::FCC_IDX, load_tab[i][2]);
			rd(gauge_pkg::STATUS_IDX, load_tab[i][3]);
		end
		$display("test load_model done");

		// A second reset mid-run, then the averaged sources over a steady 400 mA discharge.
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		check({15'h0, low_charge_pin}, 16'h0000);
		rd(gauge_pkg::CONFIG_IDX, 16'h0012);
		rd(gauge_pkg::CHARGE_IDX, 16'h0000);
		wr(gauge_pkg::CONFIG_IDX, 16'h0023);
		upd(16'hfe70, 16'h0e74, 1'b0, 1'b0);
		upd(16'hfe70, 16'h0e74, 1'b0, 1'b0);
		rd(gauge_pkg::LOAD_RATE_IDX, 16'hff9c);
		wr(gauge_pkg::CONFIG_IDX, 16'h0013);
		upd(16'hfe70, 16'h0e74, 1'b0, 1'b0);
		rd(gauge_pkg::LOAD_RATE_IDX, 16'hfe70);
		wr(gauge_pkg::CONFIG_IDX, 16'h0033);
		upd(16'hfe70, 16'h0e74, 1'b0, 1'b0);
		rd(gauge_pkg::LOAD_RATE_IDX, 16'hffed);
		wr(gauge_pkg::CONFIG_IDX, 16'h0037);
		upd(16'hfe70, 16'h0e74, 1'b0, 1'b0);
		rd(gauge_pkg::LOAD_RATE_IDX, 16'hff83);
		wr(gauge_pkg::CONFIG_IDX, 16'h0003);
		upd(16'h0000, 16'h0e74, 1'b0, 1'b0);
		upd(16'h0000, 16'h0e74, 1'b0, 1'b0);
		rd(gauge_pkg::LOAD_RATE_IDX, 16'hfe70);
		wr(gauge_pkg::CONFIG_IDX, 16'h0007);
		upd(16'h0000, 16'h0e74, 1'b0, 1'b0);
		rd(gauge_pkg::LOAD_RATE_IDX, 16'hfa38);
		rd(gauge_pkg::STATUS_IDX, 16'h0004);
		$display("test load_sources done");
		wrap_up();
	end
endmodule : charge_warning_load_model_bench
